/* File: core/owsr_top.sv */
// Contract
// R1: each sensor reading sits in its own register, 600.. and 700..
// R2: reading is 12-bit signed, sixteenths of a degree Celsius
// R3: each 64-bit identifier fills four words, 650.. and 750..
// R4: unlocked, discovery runs after reset; slots follow identifier order
// R5: writing 1 to 699 locks; locked reset keeps identifiers and slots
// R6: lock register resets to 0, permitting discovery; with lockKept set, M_BOOT loads it with 1 and skips discovery
// R7: unreadable sensor shows 4096 in its reading register
// R8: identifier registers are writable by the bus master
// R9: writing 0xdc1a to 999 starts discovery without a power cycle
// R10: master clears lock by writing 9 before rediscovery, relocks after
// R11: nine plus nine devices, data and identifiers both exposed
// R12: standard reset, presence, time slots and ROM search on the wire
// R13: poll all slots forever; old reading stays until replaced
`timescale 1ns/1ps
`default_nettype none
module owsr_top #(
   parameter int RST_LOW_CYC = owsr_pkg::RST_LOW_CYC,
   parameter int PRES_CYC = owsr_pkg::PRES_CYC,
   parameter int RST_SLOT_CYC = owsr_pkg::RST_SLOT_CYC,
   parameter int CONV_CYC = owsr_pkg::CONV_CYC
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [15:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [15:0] regWdata,
   output logic [15:0] regRdata,
   output logic regAck,
   input wire logic lockKept,
   output logic lockState,
   input wire logic owIn,
   output logic owOut,
   output logic owOe
);
   localparam owsr_pkg::owsr_tmr_t RLOW = owsr_pkg::owsr_tmr_t'(RST_LOW_CYC);
   localparam owsr_pkg::owsr_tmr_t RPRES = owsr_pkg::owsr_tmr_t'(PRES_CYC);
   localparam owsr_pkg::owsr_tmr_t REND =
      owsr_pkg::owsr_tmr_t'(RST_SLOT_CYC - 1);
   localparam owsr_pkg::owsr_tmr_t CEND = owsr_pkg::owsr_tmr_t'(CONV_CYC - 1);
   localparam owsr_pkg::owsr_tmr_t SEND = owsr_pkg::SLOT_CYC - 1'b1;

   owsr_pkg::owsr_state_t state, next_state, after, next_after;
   owsr_pkg::owsr_bit_t bState, next_bState;
   owsr_pkg::owsr_tmr_t timer, next_timer, timerInc, waitCnt, next_waitCnt;
   owsr_pkg::owsr_kind_t kind, rdKind, next_rdKind;
   logic bitOne, next_bitOne, bitDone, next_bitDone;
   logic bitSample, next_bitSample, bitGo, bitRst, bitVal;
   logic owSync1, owSync2, next_owOe;
   logic [71:0] tx, next_tx;
   logic [63:0] idCur, next_idCur;
   logic [15:0] rx, next_rx;
   logic [6:0] cnt, next_cnt, lastDisc, next_lastDisc;
   logic [6:0] lastZero, next_lastZero, pos;
   logic [5:0] bitIdx, next_bitIdx;
   logic [4:0] slot, next_slot;
   logic [2:0] word, next_word;
   logic presence, next_presence, aBit, next_aBit, dirBit, next_dirBit;
   logic searchDone, next_searchDone, discReq, next_discReq, pickDir;
   logic [15:0] temps [owsr_pkg::SLOTS];
   logic [15:0] next_temps [owsr_pkg::SLOTS];
   logic [15:0] lockValue, next_lockValue, rdTemp, next_rdTemp;
   logic [15:0] next_regRdata;
   logic next_lockState, rdPend, next_rdPend, next_regAck;

   owsr_mem_if mem ();
   owsr_id_mem u_mem (
      .sys_clk(sys_clk),
      .m(mem.mem)
   );

   function automatic owsr_pkg::owsr_kind_t addrKind(input logic [15:0] a);
      if ((a >= owsr_pkg::TEMP_LO &&
           a < owsr_pkg::TEMP_LO + owsr_pkg::BANK_SLOTS) ||
          (a >= owsr_pkg::TEMP_HI &&
           a < owsr_pkg::TEMP_HI + owsr_pkg::BANK_SLOTS))
         return owsr_pkg::K_TEMP; // R1 R11
      if ((a >= owsr_pkg::ID_LO &&
           a < owsr_pkg::ID_LO + owsr_pkg::BANK_WORDS) ||
          (a >= owsr_pkg::ID_HI &&
           a < owsr_pkg::ID_HI + owsr_pkg::BANK_WORDS))
         return owsr_pkg::K_ID; // R3 R11
      if (a == owsr_pkg::LOCK_REG)
         return owsr_pkg::K_LOCK;
      if (a == owsr_pkg::CMD_REG)
         return owsr_pkg::K_CMD;
      return owsr_pkg::K_NONE;
   endfunction

   function automatic logic [4:0] tempSlot(input logic [15:0] a);
      logic [15:0] s;
      if (a < owsr_pkg::TEMP_HI)
         s = a - owsr_pkg::TEMP_LO;
      else
         s = a - owsr_pkg::TEMP_HI + owsr_pkg::BANK_SLOTS;
      return s[4:0]; // R1
   endfunction

   function automatic logic [6:0] idIndex(input logic [15:0] a);
      logic [15:0] s;
      if (a < owsr_pkg::ID_HI)
         s = a - owsr_pkg::ID_LO;
      else
         s = a - owsr_pkg::ID_HI + owsr_pkg::BANK_WORDS;
      return s[6:0]; // R3
   endfunction

   assign kind = addrKind(regAddr);
   assign timerInc = timer + 1'b1;
   assign pos = {1'b0, bitIdx} + 7'h01;
   // branch choice for a bit where both values answered
   assign pickDir = (pos < lastDisc) ? idCur[bitIdx] : (pos == lastDisc); // R12

   // wire timing: reset pulse with presence sample, and time slots
   always_comb
   begin
      next_bState = bState;
      next_timer = timer;
      next_bitOne = bitOne;
      next_bitSample = bitSample;
      next_bitDone = 1'b0;
      next_owOe = 1'b0;
      unique case (bState)
         owsr_pkg::B_IDLE:
         begin
            if (bitGo)
            begin
               next_timer = '0;
               next_bitOne = bitVal;
               next_owOe = 1'b1;
               next_bState = bitRst ? owsr_pkg::B_RST : owsr_pkg::B_SLOT;
            end
         end
         owsr_pkg::B_SLOT:
         begin
            next_timer = timerInc;
            next_owOe = timerInc < (bitOne ? owsr_pkg::W1_LOW_CYC :
               owsr_pkg::W0_LOW_CYC); // R12
            if (timer == owsr_pkg::SAMPLE_CYC)
               next_bitSample = owSync2; // R12
            if (timer == SEND)
            begin
               next_bState = owsr_pkg::B_IDLE;
               next_bitDone = 1'b1;
               next_owOe = 1'b0;
            end
         end
         owsr_pkg::B_RST:
         begin
            next_timer = timerInc;
            next_owOe = timerInc < RLOW; // R12
            if (timer == RPRES)
               next_bitSample = !owSync2; // R12
            if (timer == REND)
            begin
               next_bState = owsr_pkg::B_IDLE;
               next_bitDone = 1'b1;
               next_owOe = 1'b0;
            end
         end
      endcase
   end

   // sequencing: discovery, polling, register side
   always_comb
   begin
      next_state = state;
      next_after = after;
      next_tx = tx;
      next_idCur = idCur;
      next_rx = rx;
      next_cnt = cnt;
      next_lastDisc = lastDisc;
      next_lastZero = lastZero;
      next_bitIdx = bitIdx;
      next_slot = slot;
      next_word = word;
      next_presence = presence;
      next_aBit = aBit;
      next_dirBit = dirBit;
      next_searchDone = searchDone;
      next_discReq = discReq;
      next_waitCnt = waitCnt;
      next_temps = temps;
      next_lockValue = lockValue;
      bitRst = (state == owsr_pkg::M_RESET);
      bitVal = 1'b1;
      bitGo = 1'b0;
      mem.bWe = 1'b0;
      mem.bAddr = {slot, word[1:0]};
      mem.bWdata = idCur[63:48];
      unique case (state)
         owsr_pkg::M_BOOT:
         begin
            next_lockValue = lockKept ? owsr_pkg::LOCK_ON : '0;
            next_state = lockKept ? owsr_pkg::M_POLL : owsr_pkg::M_DISC; // R4 R5
         end
         owsr_pkg::M_DISC:
         begin
            next_slot = '0;
            next_lastDisc = '0;
            next_searchDone = 1'b0;
            next_discReq = 1'b0;
            next_after = owsr_pkg::M_SRCH_CMD;
            next_state = owsr_pkg::M_RESET;
         end
         owsr_pkg::M_RESET:
         begin
            bitGo = !bitDone && bState == owsr_pkg::B_IDLE;
            if (bitDone)
            begin
               next_presence = bitSample;
               next_state = after;
            end
         end
         owsr_pkg::M_SRCH_CMD:
         begin
            next_word = '0;
            if (!presence)
            begin
               next_searchDone = 1'b1;
               next_idCur = '0;
               next_state = owsr_pkg::M_STORE;
            end
            else
            begin
               next_tx = {64'h0, owsr_pkg::SEARCH_ROM};
               next_cnt = owsr_pkg::CMD_BITS;
               next_bitIdx = '0;
               next_lastZero = '0;
               next_after = owsr_pkg::M_SRCH_A;
               next_state = owsr_pkg::M_TX;
            end
         end
         owsr_pkg::M_TX:
         begin
            bitVal = tx[0];
            bitGo = !bitDone && bState == owsr_pkg::B_IDLE;
            if (bitDone)
            begin
               next_tx = tx >> 1;
               next_cnt = cnt - 1'b1;
               if (cnt == 7'h01)
               begin
                  next_cnt = owsr_pkg::RX_BITS;
                  next_state = after;
               end
            end
         end
         owsr_pkg::M_SRCH_A:
         begin
            bitGo = !bitDone && bState == owsr_pkg::B_IDLE;
            if (bitDone)
            begin
               next_aBit = bitSample;
               next_state = owsr_pkg::M_SRCH_B;
            end
         end
         owsr_pkg::M_SRCH_B:
         begin
            bitGo = !bitDone && bState == owsr_pkg::B_IDLE;
            if (bitDone && aBit && bitSample)
            begin
               next_searchDone = 1'b1;
               next_idCur = '0;
               next_word = '0;
               next_state = owsr_pkg::M_STORE;
            end
            else if (bitDone)
            begin
               next_dirBit = (aBit != bitSample) ? aBit : pickDir; // R12
               next_idCur[bitIdx] = next_dirBit;
               if (aBit == bitSample && !pickDir)
                  next_lastZero = pos;
               next_state = owsr_pkg::M_SRCH_W;
            end
         end
         owsr_pkg::M_SRCH_W:
         begin
            bitVal = dirBit;
            bitGo = !bitDone && bState == owsr_pkg::B_IDLE;
            if (bitDone)
            begin
               next_bitIdx = bitIdx + 1'b1;
               next_state = owsr_pkg::M_SRCH_A;
               if (bitIdx == owsr_pkg::LAST_BIT)
               begin
                  next_word = '0;
                  next_state = owsr_pkg::M_STORE;
               end
            end
         end
         owsr_pkg::M_STORE:
         begin
            // rotate so four writes leave the identifier intact
            mem.bWe = 1'b1; // R3 R4
            next_idCur = {idCur[47:0], idCur[63:48]};
            next_word = word + 1'b1;
            if (word == owsr_pkg::LAST_WORD)
            begin
               next_word = '0;
               next_slot = slot + 1'b1;
               next_lastDisc = lastZero;
               if (slot == owsr_pkg::LAST_SLOT)
                  next_state = owsr_pkg::M_POLL;
               else if (searchDone || lastZero == '0)
               begin
                  next_searchDone = 1'b1;
                  next_idCur = '0;
               end
               else
               begin
                  next_after = owsr_pkg::M_SRCH_CMD;
                  next_state = owsr_pkg::M_RESET; // R4
               end
            end
         end
         owsr_pkg::M_POLL:
         begin
            next_after = owsr_pkg::M_CONV_CMD;
            next_state = discReq ? owsr_pkg::M_DISC : owsr_pkg::M_RESET; // R9
         end
         owsr_pkg::M_CONV_CMD:
         begin
            next_tx = {56'h0, owsr_pkg::CONVERT, owsr_pkg::SKIP_ROM};
            next_cnt = owsr_pkg::CONV_BITS;
            next_waitCnt = '0;
            next_after = owsr_pkg::M_WAIT;
            next_state = owsr_pkg::M_TX;
         end
         owsr_pkg::M_WAIT:
         begin
            next_waitCnt = waitCnt + 1'b1;
            next_slot = '0;
            next_word = '0;
            if (waitCnt == CEND)
               next_state = owsr_pkg::M_LOAD;
         end
         owsr_pkg::M_LOAD:
         begin
            next_word = word + 1'b1;
            if (word != '0)
               next_idCur = {idCur[47:0], mem.bRdata};
            if (word == owsr_pkg::LOAD_DONE)
            begin
               next_after = owsr_pkg::M_MATCH;
               next_state = owsr_pkg::M_RESET;
            end
         end
         owsr_pkg::M_MATCH:
         begin
            next_rx = owsr_pkg::ALL_ONES;
            next_tx = {idCur, owsr_pkg::MATCH_ROM};
            next_cnt = owsr_pkg::MATCH_BITS;
            next_after = owsr_pkg::M_READ_CMD;
            next_state = owsr_pkg::M_TX;
            if (!presence || idCur == '0)
            begin
               next_cnt = 7'h01;
               next_state = owsr_pkg::M_RX;
            end
         end
         owsr_pkg::M_READ_CMD:
         begin
            next_tx = {64'h0, owsr_pkg::READ_PAD};
            next_cnt = owsr_pkg::CMD_BITS;
            next_after = owsr_pkg::M_RX;
            next_state = owsr_pkg::M_TX;
         end
         owsr_pkg::M_RX:
         begin
            bitGo = !bitDone && bState == owsr_pkg::B_IDLE && rx != '0;
            if (bitDone || rx == '0)
            begin
               next_rx = {bitSample, rx[15:1]};
               next_cnt = cnt - 1'b1;
            end
            if (cnt == 7'h01 && (bitDone || rx == '0))
            begin
               // all ones means nobody answered
               next_temps[slot] = (next_rx == owsr_pkg::ALL_ONES) ?
                  owsr_pkg::NO_READ : // R7
                  16'($signed(next_rx[owsr_pkg::TEMP_W-1:0])); // R1 R2 R13
               next_slot = slot + 1'b1;
               next_word = '0;
               next_state = (slot == owsr_pkg::LAST_SLOT) ?
                  owsr_pkg::M_POLL : owsr_pkg::M_LOAD; // R13
            end
         end
      endcase
      if (regWrite && kind == owsr_pkg::K_CMD &&
          regWdata == owsr_pkg::DISC_CODE)
         next_discReq = 1'b1; // R9
      if (regWrite && kind == owsr_pkg::K_LOCK)
         next_lockValue = regWdata; // R5
      next_lockState = next_lockValue == owsr_pkg::LOCK_ON; // R5 R10
      mem.aAddr = idIndex(regAddr);
      mem.aWe = regWrite && kind == owsr_pkg::K_ID; // R8
      mem.aWdata = regWdata;
      next_rdPend = regRead;
      next_rdKind = kind;
      next_rdTemp = (kind == owsr_pkg::K_TEMP) ? temps[tempSlot(regAddr)] :
         '0; // R1
      next_regAck = rdPend;
      next_regRdata = regRdata;
      if (rdPend)
      begin
         unique case (rdKind)
            owsr_pkg::K_ID: next_regRdata = mem.aRdata; // R3
            owsr_pkg::K_TEMP: next_regRdata = rdTemp;
            owsr_pkg::K_LOCK: next_regRdata = lockValue;
            owsr_pkg::K_CMD, owsr_pkg::K_NONE: next_regRdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      owSync1 <= owIn;
      owSync2 <= owSync1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         bState <= owsr_pkg::B_IDLE;
         timer <= '0;
         bitOne <= 1'b0;
         bitSample <= 1'b0;
         bitDone <= 1'b0;
         owOe <= 1'b0;
         owOut <= 1'b0;
         state <= owsr_pkg::M_BOOT; // R4
         after <= owsr_pkg::M_BOOT;
         tx <= '0;
         idCur <= '0;
         rx <= '0;
         cnt <= '0;
         lastDisc <= '0;
         lastZero <= '0;
         bitIdx <= '0;
         slot <= '0;
         word <= '0;
         presence <= 1'b0;
         aBit <= 1'b0;
         dirBit <= 1'b0;
         searchDone <= 1'b0;
         discReq <= 1'b0;
         waitCnt <= '0;
         temps <= '{default: owsr_pkg::NO_READ}; // R7
         lockValue <= '0; // R6
         lockState <= 1'b0;
         rdPend <= 1'b0;
         rdKind <= owsr_pkg::K_NONE;
         rdTemp <= '0;
         regRdata <= '0;
         regAck <= 1'b0;
      end
      else
      begin
         bState <= next_bState;
         timer <= next_timer;
         bitOne <= next_bitOne;
         bitSample <= next_bitSample;
         bitDone <= next_bitDone;
         owOe <= next_owOe;
         owOut <= 1'b0;
         state <= next_state;
         after <= next_after;
         tx <= next_tx;
         idCur <= next_idCur;
         rx <= next_rx;
         cnt <= next_cnt;
         lastDisc <= next_lastDisc;
         lastZero <= next_lastZero;
         bitIdx <= next_bitIdx;
         slot <= next_slot;
         word <= next_word;
         presence <= next_presence;
         aBit <= next_aBit;
         dirBit <= next_dirBit;
         searchDone <= next_searchDone;
         discReq <= next_discReq;
         waitCnt <= next_waitCnt;
         temps <= next_temps;
         lockValue <= next_lockValue;
         lockState <= next_lockState;
         rdPend <= next_rdPend;
         rdKind <= next_rdKind;
         rdTemp <= next_rdTemp;
         regRdata <= next_regRdata;
         regAck <= next_regAck;
      end
   end
endmodule
`default_nettype wire

/* File: core/owsr_pkg.sv */
package owsr_pkg;
   localparam int CLK_NS = 40;
   localparam int RST_LOW_NS = 480000;
   localparam int PRES_NS = 550000;
   localparam int RST_SLOT_NS = 960000;
   localparam int W0_LOW_NS = 60000;
   localparam int W1_LOW_NS = 6000;
   localparam int SAMPLE_NS = 13000;
   localparam int SLOT_NS = 70000;
   localparam int CONV_NS = 750000000;
   localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRES_CYC = PRES_NS / CLK_NS;
   localparam int RST_SLOT_CYC = (RST_SLOT_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMR_W = 25;
   typedef logic [TMR_W-1:0] owsr_tmr_t;
   localparam owsr_tmr_t W0_LOW_CYC =
      owsr_tmr_t'((W0_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam owsr_tmr_t W1_LOW_CYC =
      owsr_tmr_t'((W1_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam owsr_tmr_t SAMPLE_CYC = owsr_tmr_t'(SAMPLE_NS / CLK_NS);
   localparam owsr_tmr_t SLOT_CYC =
      owsr_tmr_t'((SLOT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] TEMP_LO = 16'h0258;
   localparam logic [15:0] ID_LO = 16'h028a;
   localparam logic [15:0] LOCK_REG = 16'h02bb;
   localparam logic [15:0] TEMP_HI = 16'h02bc;
   localparam logic [15:0] ID_HI = 16'h02ee;
   localparam logic [15:0] CMD_REG = 16'h03e7;
   localparam logic [15:0] BANK_SLOTS = 16'h0009;
   localparam logic [15:0] BANK_WORDS = 16'h0024;
   localparam int SLOTS = 18;
   localparam logic [4:0] LAST_SLOT = 5'h11;
   localparam int MEM_DEPTH = 72;
   localparam int MEM_AW = 7;
   localparam logic [2:0] LAST_WORD = 3'h3;
   localparam logic [2:0] LOAD_DONE = 3'h4;
   localparam logic [15:0] DISC_CODE = 16'hdc1a;
   localparam logic [15:0] LOCK_ON = 16'h0001;
   localparam logic [15:0] NO_READ = 16'h1000;
   localparam logic [15:0] ALL_ONES = 16'hffff;
   localparam int TEMP_W = 12;
   localparam logic [7:0] SEARCH_ROM = 8'hf0;
   localparam logic [7:0] SKIP_ROM = 8'hcc;
   localparam logic [7:0] MATCH_ROM = 8'h55;
   localparam logic [7:0] CONVERT = 8'h44;
   localparam logic [7:0] READ_PAD = 8'hbe;
   localparam logic [6:0] CMD_BITS = 7'h08;
   localparam logic [6:0] CONV_BITS = 7'h10;
   localparam logic [6:0] MATCH_BITS = 7'h48;
   localparam logic [6:0] RX_BITS = 7'h10;
   localparam logic [5:0] LAST_BIT = 6'h3f;
   typedef enum logic [3:0] {M_BOOT, M_DISC, M_RESET, M_SRCH_CMD, M_TX,
      M_SRCH_A, M_SRCH_B, M_SRCH_W, M_STORE, M_POLL, M_CONV_CMD, M_WAIT,
      M_LOAD, M_MATCH, M_READ_CMD, M_RX} owsr_state_t;
   typedef enum logic [1:0] {B_IDLE, B_SLOT, B_RST} owsr_bit_t;
   typedef enum logic [2:0] {K_NONE, K_TEMP, K_ID, K_LOCK, K_CMD}
      owsr_kind_t;
endpackage

/* File: core/owsr_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface owsr_mem_if;
   logic [owsr_pkg::MEM_AW-1:0] aAddr;
   logic aWe;
   logic [15:0] aWdata;
   logic [15:0] aRdata;
   logic [owsr_pkg::MEM_AW-1:0] bAddr;
   logic bWe;
   logic [15:0] bWdata;
   logic [15:0] bRdata;
   modport mem (input aAddr, aWe, aWdata, bAddr, bWe, bWdata,
      output aRdata, bRdata);
   modport user (output aAddr, aWe, aWdata, bAddr, bWe, bWdata,
      input aRdata, bRdata);
endinterface
`default_nettype wire

/* File: core/owsr_id_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module owsr_id_mem (
   input wire logic sys_clk,
   owsr_mem_if.mem m
);
   logic [15:0] store [owsr_pkg::MEM_DEPTH];

   // port a is the register side, it wins a same-word collision
   always_ff @(posedge sys_clk)
   begin
      if (m.bWe)
      begin
         store[m.bAddr] <= m.bWdata;
      end
      if (m.aWe)
      begin
         store[m.aAddr] <= m.aWdata;
      end
      m.aRdata <= store[m.aAddr];
      m.bRdata <= store[m.bAddr];
   end
endmodule
`default_nettype wire

/* File: tb/owsr_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module owsr_top_properties (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [15:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [15:0] regWdata,
   input wire logic [15:0] regRdata,
   input wire logic regAck,
   input wire logic lockKept,
   input wire logic lockState,
   input wire logic owIn,
   input wire logic owOut,
   input wire logic owOe
);
   logic [10:0] oeRun;
   logic [10:0] next_oeRun;
   logic lockWr;
   assign lockWr = regWrite && regAddr == owsr_pkg::LOCK_REG;
   always_comb next_oeRun = owOe ? oeRun + 11'h001 : 11'h000;
   always_ff @(posedge sys_clk) oeRun <= rst ? 11'h000 : next_oeRun;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_ack_exact;
      !$past(rst) && !$past(rst, 2) |-> regAck == $past(regRead, 2);
   endproperty
   a_ack_exact: assert property (p_ack_exact)
      else $error("read answer out of step");
   property p_rdata_hold;
      !regAck && !$past(rst) |-> $stable(regRdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without answer");
   property p_lock_on;
      lockWr && regWdata == owsr_pkg::LOCK_ON |-> ##2 lockState;
   endproperty
   a_lock_on: assert property (p_lock_on)
      else $error("lock not set");
   property p_lock_off;
      lockWr && regWdata != owsr_pkg::LOCK_ON |-> ##2 !lockState;
   endproperty
   a_lock_off: assert property (p_lock_off)
      else $error("lock not cleared");
   property p_rst_clear;
      $past(rst) |-> !lockState && !regAck && !owOe && regRdata == 16'h0000;
   endproperty
   a_rst_clear: assert property (p_rst_clear)
      else $error("outputs not cleared by reset");
   property p_drive_low;
      owOe |-> !owOut;
   endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("line driven high");
   property p_oe_min;
      $rose(owOe) |=> owOe [*8];
   endproperty
   a_oe_min: assert property (p_oe_min)
      else $error("line pulse too short");
   property p_oe_max;
      oeRun <= 11'h5dc;
   endproperty
   a_oe_max: assert property (p_oe_max)
      else $error("line held low too long");
   c_read: cover property (regAck);
   c_lock: cover property (lockState);
   c_zero: cover property ($fell(owOe) && oeRun > 11'h064);
endmodule
`default_nettype wire

/* File: tb/owsr_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module owsr_sensor_model #(
   parameter int RST_MIN = 16,
   parameter int RST_MAX = 100,
   parameter int PRES_DELAY = 1
)(
   input wire logic sys_clk,
   input wire logic lineLevel,
   output logic pullLow
);
   int lowRun = 0;
   int sinceRise = 1000;
   // presence answer after a shortened reset pulse
   always @(posedge sys_clk)
   begin
      lowRun <= lineLevel ? 0 : lowRun + 1;
      if (lineLevel && lowRun >= RST_MIN && lowRun <= RST_MAX)
         sinceRise <= 0;
      else if (sinceRise < 1000)
         sinceRise <= sinceRise + 1;
   end
   assign pullLow = sinceRise >= PRES_DELAY && sinceRise < PRES_DELAY + 12;
endmodule
`default_nettype wire

/* File: tb/owsr_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module owsr_top_tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] regAddr = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] regWdata = 16'h0000;
   logic [15:0] regRdata;
   logic regAck;
   logic lockKept = 1'b0;
   logic lockState;
   logic owOut;
   logic owOe;
   logic pullLow;
   logic owIn;
   int errors = 0;
   int check_count = 0;
   int seed = 32'h076a;
   logic [31:0] rv;
   logic [15:0] idStore [0:71];
   assign owIn = !(owOe || pullLow);
   initial
   begin
      forever #20 sys_clk = ~sys_clk;
   end
   owsr_top #(.RST_LOW_CYC(20), .PRES_CYC(25), .RST_SLOT_CYC(40),
      .CONV_CYC(50)) owsr_top_i (.sys_clk(sys_clk), .rst(rst),
      .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
      .lockKept(lockKept), .lockState(lockState), .owIn(owIn),
      .owOut(owOut), .owOe(owOe));
   owsr_sensor_model #(.PRES_DELAY(2)) owsr_sensor_model_i (
      .sys_clk(sys_clk), .lineLevel(owIn), .pullLow(pullLow));
   function automatic logic [15:0] idAddr(input int s, input int w);
      if (s < 9)
         return owsr_pkg::ID_LO + 16'(4 * s + w);
      return owsr_pkg::ID_HI + 16'(4 * (s - 9) + w);
   endfunction
   function automatic logic [15:0] tAddr(input int s);
      if (s < 9)
         return owsr_pkg::TEMP_LO + 16'(s);
      return owsr_pkg::TEMP_HI + 16'(s - 9);
   endfunction
   function automatic logic [15:0] expLow(input logic [7:0] c, input int k);
      if (k < 0)
         return 16'h0014;
      return c[k] ? 16'(owsr_pkg::W1_LOW_CYC) : 16'(owsr_pkg::W0_LOW_CYC);
   endfunction
   task automatic chk(input string n, input logic [15:0] s, e);
      check_count++;
      if (s !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge sys_clk);
      regWrite = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic rdc(input logic [15:0] a, e, input string n);
      regAddr = a;
      regRead = 1'b1;
      @(negedge sys_clk);
      regRead = 1'b0;
      @(negedge sys_clk);
      chk("ack", 16'(regAck), 16'h0001);
      chk(n, regRdata, e);
   endtask
   task automatic do_reset(input logic kept);
      lockKept = kept;
      rst = 1'b1;
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
   endtask
   task automatic pulses(input logic [7:0] c);
      int n;
      for (int k = -1; k < 8; k++)
      begin
         n = 0;
         while (owOe !== 1'b1 && n < 4000)
         begin
            @(negedge sys_clk);
            n++;
         end
         n = 0;
         while (owOe === 1'b1)
         begin
            @(negedge sys_clk);
            n++;
         end
         chk("low time", 16'(n), expLow(c, k));
      end
   endtask
   task automatic ids;
      for (int i = 0; i < 72; i++)
         rdc(idAddr(i / 4, i % 4), idStore[i], "id");
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      errors++;
      print_verdict;
   end
   initial
   begin
      do_reset(1'b0);
      pulses(owsr_pkg::SEARCH_ROM);
      repeat (6000) @(negedge sys_clk);
      rdc(idAddr(17, 3), 16'h0000, "id");
      rdc(owsr_pkg::LOCK_REG, 16'h0000, "lock");
      for (int s = 0; s < 18; s++)
      begin
         rv = $random(seed);
         wr(tAddr(s), rv[15:0]);
         rdc(tAddr(s), owsr_pkg::NO_READ, "reading");
         for (int w = 0; w < 4; w++)
         begin
            rv = $random(seed);
            idStore[4 * s + w] = rv[15:0];
            wr(idAddr(s, w), rv[15:0]);
         end
      end
      ids;
      rdc(owsr_pkg::ID_HI + 16'h0024, 16'h0000, "unmapped");
      wr(owsr_pkg::LOCK_REG, owsr_pkg::LOCK_ON);
      rdc(owsr_pkg::LOCK_REG, owsr_pkg::LOCK_ON, "lock");
      chk("lock state", 16'(lockState), 16'h0001);
      wr(owsr_pkg::LOCK_REG, 16'h0009);
      rdc(owsr_pkg::LOCK_REG, 16'h0009, "lock");
      chk("lock state", 16'(lockState), 16'h0000);
      wr(owsr_pkg::CMD_REG, owsr_pkg::DISC_CODE);
      rdc(owsr_pkg::CMD_REG, 16'h0000, "command");
      wr(owsr_pkg::LOCK_REG, owsr_pkg::LOCK_ON);
      do_reset(1'b1);
      pulses(owsr_pkg::SKIP_ROM);
      ids;
      rdc(owsr_pkg::LOCK_REG, owsr_pkg::LOCK_ON, "lock");
      print_verdict;
   end
endmodule
bind owsr_top owsr_top_properties owsr_top_properties_i (
   .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
   .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
   .regAck(regAck), .lockKept(lockKept), .lockState(lockState),
   .owIn(owIn), .owOut(owOut), .owOe(owOe));
`default_nettype wire
